// File: hw/nested_irq_pkg.sv
// Function
// - fixed vectors: reset FFFE, trap FFFC, top pin FFFA; reset and top pin wake halt
// - vectors 0..13 descend in pairs from FFFA; lower number ranks higher; 6 unused
// - external groups on vectors 2..5: porta low, portf, portb low, portb high; all wake
// - timebase on vector 1 wakes halt; only it or reset wakes active halt
// - spi vector 7 wakes halt only while spi is a slave
// - pwm timer vector 13 wakes halt only on its external clock
// - timers 8, 9, serial, voltage detect, i2c never wake; requests stay pending
// - sense field 7:6 serves portb groups, field 4:3 serves porta and portf groups
// - sense codes: 00 fall+low, 01 rise, 10 fall, 11 both edges
// - polarity bit inverts low nibble group: 00 rise+high, 01 fall, 10 rise, 11 both
// - sense and polarity bits written only at current priority level 3
// - writing a changed sense or polarity value clears pending external requests
// - top edge select: 0 falling, 1 rising; writable only while top enable clear
// - top enable turns pin detection on; clearing may give one spurious request
// - four priority registers, 2 bits per vector, top vector at bits 1:0; reset ones
// - external control register resets to zero
// - selected pins of one group are ored onto one request line
// - edge requests latch and clear when their service routine is entered
// - maskable request served only if enabled and its priority beats current level
// - level-0 code writes are ignored per field; priority_3 upper nibble reads ones
package nested_irq_pkg;
  localparam logic [7:0] ADDR_PRIO_0 = 8'h24;
  localparam logic [7:0] ADDR_PRIO_1 = 8'h25;
  localparam logic [7:0] ADDR_PRIO_2 = 8'h26;
  localparam logic [7:0] ADDR_PRIO_3 = 8'h27;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h28;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [7:0] PRIO_3_RO_ONES = 8'hf0;
  localparam int PORTB_SENSE_LSB = 6;
  localparam int PORTB_POL_BIT = 5;
  localparam int PORTA_SENSE_LSB = 3;
  localparam int PORTA_POL_BIT = 2;
  localparam int TOP_EDGE_BIT = 1;
  localparam int TOP_EN_BIT = 0;
  localparam logic [7:0] EXT_LOCK_MASK = 8'hfc;
  localparam logic [1:0] LEVEL_0 = 2'b10;
  localparam logic [1:0] LEVEL_1 = 2'b01;
  localparam logic [1:0] LEVEL_2 = 2'b00;
  localparam logic [1:0] LEVEL_3 = 2'b11;
  localparam logic [1:0] SENSE_FALL_LOW = 2'b00;
  localparam logic [1:0] SENSE_RISE = 2'b01;
  localparam logic [1:0] SENSE_FALL = 2'b10;
  localparam logic [1:0] SENSE_BOTH = 2'b11;
  localparam int NUM_VEC = 14;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_BASE = 16'hfffa;
  localparam int VEC_TOP = 0;
  localparam int VEC_TIMEBASE = 1;
  localparam int VEC_EXT_A = 2;
  localparam int VEC_EXT_F = 3;
  localparam int VEC_EXT_BL = 4;
  localparam int VEC_EXT_BH = 5;
  localparam int VEC_UNUSED = 6;
  localparam int VEC_SPI = 7;
  localparam int VEC_PWM = 13;
  localparam logic [13:0] WAKE_ALWAYS = 14'h003f;
endpackage

// File: hw/nested_irq_vector_ext_sense.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module nested_irq_vector_ext_sense #(
  parameter int PORTA_W = 4,
  parameter int PORTF_W = 3,
  parameter int PORTB_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] cur_prio_in,
  input wire logic [PORTA_W-1:0] porta_pins_in,
  input wire logic [PORTA_W-1:0] porta_sel_in,
  input wire logic [PORTF_W-1:0] portf_pins_in,
  input wire logic [PORTF_W-1:0] portf_sel_in,
  input wire logic [PORTB_W-1:0] portb_pins_in,
  input wire logic [PORTB_W-1:0] portb_sel_in,
  input wire logic top_pin_in,
  input wire logic [13:0] periph_req_in,
  input wire logic [13:0] enable_in,
  input wire logic spi_slave_in,
  input wire logic pwm_ext_clk_in,
  input wire logic halted_in,
  input wire logic active_halt_in,
  input wire logic ack_in,
  input wire logic [3:0] ack_vec_in,
  output logic irq_valid_out,
  output logic [3:0] irq_vec_out,
  output logic [15:0] irq_addr_out,
  output logic [1:0] irq_level_out,
  output logic wake_out,
  output logic [13:0] pending_out
);
  logic [7:0] prio_r [4];
  logic [7:0] ext_ctrl_r;
  logic [3:0] grp_s_r;
  logic [3:0] grp_p_r;
  logic top_s_r;
  logic top_p_r;
  logic [3:0] ext_pend_r;
  logic top_pend_r;
  logic [7:0] rdata_nxt;
  logic [3:0] grp_now;
  logic [3:0] grp_evt;
  logic [1:0] grp_code [4];
  logic [3:0] grp_inv;
  logic top_evt;
  logic [13:0] req;
  logic [13:0] wake_mask;
  logic [13:0] wake_req;
  logic found;
  logic [3:0] best_vec;
  logic [1:0] best_lvl;
  logic [7:0] ext_nxt;
  logic ext_wr;

  // level code to rank: 0 lowest, 3 highest (interrupts disabled)
  function automatic logic [1:0] rank(input logic [1:0] lvl);
    case (lvl)
      nested_irq_pkg::LEVEL_0: rank = 2'd0;
      nested_irq_pkg::LEVEL_1: rank = 2'd1;
      nested_irq_pkg::LEVEL_2: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  function automatic logic [1:0] prio_of(input int v);
    logic [7:0] r;
    r = prio_r[v / 4];
    prio_of = r[(v % 4) * 2 +: 2];
  endfunction

  // keep old field where software writes the level-0 code
  function automatic logic [7:0] prio_merge(input logic [7:0] old_v, input logic [7:0] new_v);
    logic [7:0] m;
    m = new_v;
    for (int f = 0; f < 4; f++)
    begin
      if (new_v[f*2 +: 2] == nested_irq_pkg::LEVEL_0)
      begin
        m[f*2 +: 2] = old_v[f*2 +: 2];
      end
    end
    prio_merge = m;
  endfunction

  // sense: edge or level per code; inv swaps polarity
  function automatic logic sense_hit(input logic [1:0] code, input logic inv,
                                     input logic now_v, input logic prev_v);
    logic rise;
    logic fall;
    logic lvl;
    rise = now_v & ~prev_v;
    fall = ~now_v & prev_v;
    lvl = inv ? now_v : ~now_v;
    case (code)
      nested_irq_pkg::SENSE_FALL_LOW: sense_hit = lvl | (inv ? rise : fall);
      nested_irq_pkg::SENSE_RISE: sense_hit = inv ? fall : rise;
      nested_irq_pkg::SENSE_FALL: sense_hit = inv ? rise : fall;
      default: sense_hit = rise | fall;
    endcase
  endfunction

  always_comb
  begin
    grp_now[0] = |(porta_pins_in & porta_sel_in);
    grp_now[1] = |(portf_pins_in & portf_sel_in);
    grp_now[2] = |(portb_pins_in[3:0] & portb_sel_in[3:0]);
    grp_now[3] = |(portb_pins_in[7:4] & portb_sel_in[7:4]);
  end

  always_comb
  begin
    grp_code[0] = ext_ctrl_r[nested_irq_pkg::PORTA_SENSE_LSB +: 2];
    grp_code[1] = ext_ctrl_r[nested_irq_pkg::PORTA_SENSE_LSB +: 2];
    grp_code[2] = ext_ctrl_r[nested_irq_pkg::PORTB_SENSE_LSB +: 2];
    grp_code[3] = ext_ctrl_r[nested_irq_pkg::PORTB_SENSE_LSB +: 2];
    grp_inv[0] = ext_ctrl_r[nested_irq_pkg::PORTA_POL_BIT];
    grp_inv[1] = 1'b0;
    grp_inv[2] = ext_ctrl_r[nested_irq_pkg::PORTB_POL_BIT];
    grp_inv[3] = 1'b0;
    for (int g = 0; g < 4; g++)
    begin
      grp_evt[g] = sense_hit(grp_code[g], grp_inv[g], grp_now[g], grp_p_r[g]);
    end
  end

  // top pin edge; a falling enable can leave one stray request
  always_comb
  begin
    if (ext_ctrl_r[nested_irq_pkg::TOP_EDGE_BIT])
    begin
      top_evt = top_pin_in & ~top_p_r;
    end
    else
    begin
      top_evt = ~top_pin_in & top_p_r;
    end
    top_evt = top_evt & ext_ctrl_r[nested_irq_pkg::TOP_EN_BIT];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      // load the live pins so no false edge follows reset
      grp_p_r <= grp_now;
      top_p_r <= top_pin_in;
    end
    else
    begin
      grp_p_r <= grp_now;
      top_p_r <= top_pin_in;
    end
  end

  // locked fields need level 3; edge select needs only enable clear, at any level
  always_comb
  begin
    ext_wr = wr_in && addr_in == nested_irq_pkg::ADDR_EXT_CTRL;
    ext_nxt = ext_ctrl_r;
    if (cur_prio_in == nested_irq_pkg::LEVEL_3)
    begin
      ext_nxt = (ext_nxt & ~nested_irq_pkg::EXT_LOCK_MASK)
              | (wdata_in & nested_irq_pkg::EXT_LOCK_MASK);
    end
    if (!ext_ctrl_r[nested_irq_pkg::TOP_EN_BIT])
    begin
      ext_nxt[nested_irq_pkg::TOP_EDGE_BIT] = wdata_in[nested_irq_pkg::TOP_EDGE_BIT];
    end
    ext_nxt[nested_irq_pkg::TOP_EN_BIT] = wdata_in[nested_irq_pkg::TOP_EN_BIT];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      ext_ctrl_r <= nested_irq_pkg::EXT_CTRL_RESET;
    end
    else if (ext_wr)
    begin
      ext_ctrl_r <= ext_nxt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        prio_r[i] <= nested_irq_pkg::PRIO_RESET;
      end
    end
    else if (wr_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (addr_in == nested_irq_pkg::ADDR_PRIO_0 + 8'(i))
        begin
          prio_r[i] <= prio_merge(prio_r[i], wdata_in);
        end
      end
      if (addr_in == nested_irq_pkg::ADDR_PRIO_3)
      begin
        prio_r[3] <= prio_merge(prio_r[3], wdata_in) | nested_irq_pkg::PRIO_3_RO_ONES;
      end
    end
  end

  // pending external latches; a changed locked field clears them,
  // but a new event in that same cycle still sets
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      ext_pend_r <= 4'h0;
      top_pend_r <= 1'b0;
    end
    else
    begin
      for (int g = 0; g < 4; g++)
      begin
        if (grp_evt[g])
        begin
          ext_pend_r[g] <= 1'b1;
        end
        else if ((ext_wr && ((ext_nxt ^ ext_ctrl_r) & nested_irq_pkg::EXT_LOCK_MASK) != 8'h00)
                 || (ack_in && ack_vec_in == 4'(nested_irq_pkg::VEC_EXT_A + g)))
        begin
          ext_pend_r[g] <= 1'b0;
        end
      end
      if (top_evt)
      begin
        top_pend_r <= 1'b1;
      end
      else if (ack_in && ack_vec_in == 4'(nested_irq_pkg::VEC_TOP))
      begin
        top_pend_r <= 1'b0;
      end
    end
  end

  always_comb
  begin
    req = periph_req_in;
    req[nested_irq_pkg::VEC_TOP] = top_pend_r;
    req[nested_irq_pkg::VEC_EXT_A +: 4] = ext_pend_r;
    req[nested_irq_pkg::VEC_UNUSED] = 1'b0;
  end

  // halt exit sources; the rest simply stay pending
  always_comb
  begin
    wake_mask = nested_irq_pkg::WAKE_ALWAYS;
    wake_mask[nested_irq_pkg::VEC_SPI] = spi_slave_in;
    wake_mask[nested_irq_pkg::VEC_PWM] = pwm_ext_clk_in;
    if (active_halt_in)
    begin
      wake_mask = 14'h0000;
      wake_mask[nested_irq_pkg::VEC_TIMEBASE] = 1'b1;
    end
    wake_req = req & enable_in & wake_mask;
    wake_req[nested_irq_pkg::VEC_TOP] = req[nested_irq_pkg::VEC_TOP] && !active_halt_in;
  end

  // top vector ignores priority; maskable ones must beat the current level
  always_comb
  begin
    found = 1'b0;
    best_vec = 4'h0;
    best_lvl = 2'b00;
    if (req[nested_irq_pkg::VEC_TOP] && !halted_in)
    begin
      found = 1'b1;
      best_lvl = nested_irq_pkg::LEVEL_3;
    end
    else
    begin
      for (int v = nested_irq_pkg::NUM_VEC - 1; v >= 1; v--)
      begin
        if (req[v] && enable_in[v] && !halted_in
            && rank(prio_of(v)) > rank(cur_prio_in)
            && (!found || rank(prio_of(v)) >= rank(best_lvl)))
        begin
          found = 1'b1;
          best_vec = 4'(v);
          best_lvl = prio_of(v);
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      irq_valid_out <= 1'b0;
      irq_vec_out <= 4'h0;
      irq_addr_out <= nested_irq_pkg::VEC_RESET;
      irq_level_out <= nested_irq_pkg::LEVEL_3;
      wake_out <= 1'b0;
      pending_out <= 14'h0000;
    end
    else
    begin
      irq_valid_out <= found && !ack_in;
      irq_vec_out <= best_vec;
      irq_addr_out <= nested_irq_pkg::VEC_BASE - {11'h000, best_vec, 1'b0};
      irq_level_out <= best_lvl;
      wake_out <= halted_in && (wake_req != 14'h0000);
      pending_out <= req;
    end
  end

  always_comb
  begin
    rdata_nxt = 8'h00;
    case (addr_in)
      nested_irq_pkg::ADDR_PRIO_0: rdata_nxt = prio_r[0];
      nested_irq_pkg::ADDR_PRIO_1: rdata_nxt = prio_r[1];
      nested_irq_pkg::ADDR_PRIO_2: rdata_nxt = prio_r[2];
      nested_irq_pkg::ADDR_PRIO_3: rdata_nxt = prio_r[3] | nested_irq_pkg::PRIO_3_RO_ONES;
      nested_irq_pkg::ADDR_EXT_CTRL: rdata_nxt = ext_ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      rdata_out <= 8'h00;
    end
    else if (rd_in)
    begin
      rdata_out <= rdata_nxt;
    end
    else
    begin
      rdata_out <= 8'h00;
    end
  end
endmodule

// File: testbench/nested_irq_vector_ext_sense_asserts.sv
`timescale 1ns/1ps
module nested_irq_asserts (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] cur_prio_in,
  input wire logic [13:0] enable_in,
  input wire logic halted_in,
  input wire logic active_halt_in,
  input wire logic irq_valid_out,
  input wire logic [3:0] irq_vec_out,
  input wire logic [15:0] irq_addr_out,
  input wire logic [1:0] irq_level_out,
  input wire logic wake_out,
  input wire logic [13:0] pending_out
);
  logic [13:0] en_d_r;
  // level codes are not ordered numerically, so rank them
  function automatic int rank(input logic [1:0] c);
    return (c == 2'h2) ? 0 : (c == 2'h1) ? 1 : (c == 2'h0) ? 2 : 3;
  endfunction
  always_ff @(posedge clk_in)
  begin
    en_d_r <= enable_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_ro_ones; rd_in && addr_in == 8'h27 |=> rdata_out[7:4] == 4'hf; endproperty
  a_ro_ones: assert property (p_ro_ones) else $error("upper nibble not ones");
  property p_vec_addr; irq_valid_out |-> irq_addr_out == 16'hfffa - {11'h000, irq_vec_out, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
  property p_top_lvl; irq_valid_out && irq_vec_out == 4'h0 |-> irq_level_out == 2'h3; endproperty
  a_top_lvl: assert property (p_top_lvl) else $error("top level not 3");
  property p_beats;
    irq_valid_out && irq_vec_out != 4'h0 |-> rank(irq_level_out) > rank($past(cur_prio_in));
  endproperty
  a_beats: assert property (p_beats) else $error("level does not beat current");
  property p_enabled; irq_valid_out && irq_vec_out != 4'h0 |-> en_d_r[irq_vec_out]; endproperty
  a_enabled: assert property (p_enabled) else $error("disabled vector served");
  property p_halt_hold; halted_in && $past(halted_in) |-> !irq_valid_out; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("served while halted");
  property p_wake_halt; wake_out |-> $past(halted_in); endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake while running");
  property p_active;
    wake_out && $past(active_halt_in) |-> pending_out[1] || $past(pending_out[1]);
  endproperty
  a_active: assert property (p_active) else $error("active halt woken wrongly");
endmodule

// File: testbench/periph_flag_model.sv
`timescale 1ns/1ps
module periph_flag_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [13:0] set_in,
  input wire logic [13:0] clr_in,
  output logic [13:0] req_out
);
  // a flag holds until software clears it, like a status bit
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      req_out <= 14'h0000;
    else
      req_out <= (req_out | set_in) & ~clr_in;
  end
endmodule

// File: testbench/nested_irq_vector_ext_sense_bench.sv
`timescale 1ns/1ps
module nested_irq_vector_ext_sense_bench;
  logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, top_pin_in = 1'b1;
  logic spi_slave_in = 1'b0, pwm_ext_clk_in = 1'b0, halted_in = 1'b0, active_halt_in = 1'b0;
  logic ack_in = 1'b0, irq_valid_out, wake_out;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, portb_pins_in = 8'hff;
  logic [1:0] cur_prio_in = 2'h3, irq_level_out;
  logic [3:0] porta_pins_in = 4'hf, ack_vec_in = 4'h0, irq_vec_out;
  logic [2:0] portf_pins_in = 3'h7;
  logic [13:0] enable_in = 14'h0000, flag_set = 14'h0000, flag_clr = 14'h0000;
  logic [13:0] periph_req_in, pending_out;
  logic [15:0] irq_addr_out;
  int fails = 0, checks_done = 0;
  localparam logic [7:0] CFG [7] = '{8'h08, 8'h10, 8'h18, 8'h0c, 8'h14, 8'h1c, 8'h04};
  localparam logic [6:0] RISE = 7'h75;
  localparam logic [6:0] FALL = 7'h6e;
  always #2 clk_in = ~clk_in;
  nested_irq_vector_ext_sense dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .cur_prio_in(cur_prio_in), .porta_pins_in(porta_pins_in), .porta_sel_in(4'h1),
    .portf_pins_in(portf_pins_in), .portf_sel_in(3'h5), .portb_pins_in(portb_pins_in),
    .portb_sel_in(8'h81), .top_pin_in(top_pin_in), .periph_req_in(periph_req_in),
    .enable_in(enable_in), .spi_slave_in(spi_slave_in), .pwm_ext_clk_in(pwm_ext_clk_in),
    .halted_in(halted_in), .active_halt_in(active_halt_in), .ack_in(ack_in),
    .ack_vec_in(ack_vec_in), .irq_valid_out(irq_valid_out), .irq_vec_out(irq_vec_out),
    .irq_addr_out(irq_addr_out), .irq_level_out(irq_level_out), .wake_out(wake_out),
    .pending_out(pending_out));
  periph_flag_model flags_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(flag_set),
    .clr_in(flag_clr), .req_out(periph_req_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk("rdata", 16'(rdata_out), 16'(e));
    @(posedge clk_in);
  endtask
  task automatic ack(input logic [3:0] v);
    @(posedge clk_in);
    ack_in <= 1'b1;
    ack_vec_in <= v;
    @(posedge clk_in);
    ack_in <= 1'b0;
  endtask
  // one halted wake case: raise a flag, qualify it, read wake, clear the flag
  task automatic wake_case(input logic [13:0] m, input logic s, p, a, e);
    flag_set <= m;
    spi_slave_in <= s;
    pwm_ext_clk_in <= p;
    active_halt_in <= a;
    cyc(1);
    flag_set <= 14'h0000;
    cyc(3);
    #1 chk("wake", 16'(wake_out), 16'(e));
    cyc(1);
    flag_clr <= m;
    cyc(1);
    flag_clr <= 14'h0000;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
      rd(8'h24 + i[7:0], 8'hff);
    rd(8'h28, 8'h00);
    wr(8'h24, 8'hcf);
    wr(8'h24, 8'h64);
    rd(8'h24, 8'h44);
    wr(8'h27, 8'h00);
    rd(8'h27, 8'hf0);
    wr(8'h24, 8'hff);
    cur_prio_in <= 2'h2;
    wr(8'h28, 8'hfc);
    rd(8'h28, 8'h00);
    cur_prio_in <= 2'h3;
    wr(8'h28, 8'h01);
    wr(8'h28, 8'h03);
    rd(8'h28, 8'h01);
    wr(8'h28, 8'h00);
    wr(8'h28, 8'h02);
    rd(8'h28, 8'h02);
  endtask
  task automatic t_sense;
    for (int i = 0; i < 7; i++)
    begin
      porta_pins_in <= 4'h0;
      wr(8'h28, CFG[i]);
      ack(4'h2);
      cyc(3);
      porta_pins_in <= 4'h1;
      cyc(4);
      #1 chk("rise", 16'(pending_out[2]), 16'(RISE[i]));
      ack(4'h2);
      cyc(2);
      porta_pins_in <= 4'h0;
      cyc(4);
      #1 chk("fall", 16'(pending_out[2]), 16'(FALL[i]));
      cyc(1);
    end
  endtask
  task automatic t_ext;
    portb_pins_in <= 8'h7f;
    ack(4'h5);
    cyc(3);
    #1 chk("low level", 16'(pending_out[5]), 16'h0001);
    cyc(1);
    portb_pins_in <= 8'hff;
    ack(4'h5);
    cyc(3);
    #1 chk("entry clear", 16'(pending_out[5]), 16'h0000);
    wr(8'h28, 8'h84);
    portb_pins_in <= 8'h7f;
    cyc(4);
    wr(8'h28, 8'hc4);
    cyc(2);
    #1 chk("change clear", 16'(pending_out[5]), 16'h0000);
    cyc(1);
    portb_pins_in <= 8'hff;
    cyc(4);
    wr(8'h28, 8'hc4);
    cyc(2);
    #1 chk("same keeps", 16'(pending_out[5]), 16'h0001);
    wr(8'h28, 8'hc5);
    top_pin_in <= 1'b0;
    cyc(4);
    #1 chk("top vec", {irq_valid_out, 11'h000, irq_vec_out}, 16'h8000);
    chk("top addr", irq_addr_out, 16'hfffa);
    ack(4'h0);
    top_pin_in <= 1'b1;
    cyc(4);
    #1 chk("top rise", 16'(irq_valid_out), 16'h0000);
    wr(8'h28, 8'hc4);
    wr(8'h28, 8'hc6);
    wr(8'h28, 8'hc7);
    top_pin_in <= 1'b0;
    cyc(3);
    #1 chk("top fall sel", 16'(irq_valid_out), 16'h0000);
    cyc(1);
    top_pin_in <= 1'b1;
    cyc(4);
    #1 chk("top rise sel", {irq_valid_out, 11'h000, irq_vec_out}, 16'h8000);
    ack(4'h0);
    wr(8'h28, 8'hc5);
    rd(8'h28, 8'hc7);
    wr(8'h28, 8'hc4);
    wr(8'h28, 8'hc4);
    rd(8'h28, 8'hc4);
    wr(8'h28, 8'h24);
    cyc(2);
    #1 chk("portb invert", 16'(pending_out[5:4]), 16'h0001);
    cyc(1);
    wr(8'h28, 8'hc4);
    ack(4'h4);
    portf_pins_in <= 3'h3;
    cyc(3);
    #1 chk("or one high", 16'(pending_out[3]), 16'h0000);
    cyc(1);
    portf_pins_in <= 3'h2;
    cyc(3);
    #1 chk("or all low", 16'(pending_out[3]), 16'h0001);
    cyc(1);
    portf_pins_in <= 3'h7;
    ack(4'h3);
    cyc(2);
    #1 chk("or cleared", 16'(pending_out[3]), 16'h0000);
    ack(4'h2);
    ack(4'h5);
  endtask
  task automatic t_arb;
    enable_in <= 14'h0300;
    wr(8'h26, 8'hf1);
    flag_set <= 14'h0300;
    cur_prio_in <= 2'h2;
    cyc(1);
    flag_set <= 14'h0000;
    cyc(4);
    #1 chk("arb vec", 16'(irq_vec_out), 16'h0009);
    chk("arb addr", irq_addr_out, 16'hffe8);
    chk("arb lvl", 16'(irq_level_out), 16'h0000);
    cyc(1);
    cur_prio_in <= 2'h0;
    cyc(4);
    #1 chk("masked", 16'(irq_valid_out), 16'h0000);
    cyc(1);
    cur_prio_in <= 2'h2;
    halted_in <= 1'b1;
    cyc(4);
    #1 chk("no wake", {wake_out, irq_valid_out}, 16'h0000);
    cyc(1);
    halted_in <= 1'b0;
    wr(8'h26, 8'hf0);
    cyc(4);
    #1 chk("tie vec", {irq_valid_out, 11'h000, irq_vec_out}, 16'h8008);
    cyc(1);
    flag_clr <= 14'h0300;
    enable_in <= 14'h3fff;
    halted_in <= 1'b1;
    cyc(1);
    flag_clr <= 14'h0000;
    wake_case(14'h0080, 1'b0, 1'b0, 1'b0, 1'b0);
    wake_case(14'h0080, 1'b1, 1'b0, 1'b0, 1'b1);
    wake_case(14'h2000, 1'b0, 1'b0, 1'b0, 1'b0);
    wake_case(14'h2000, 1'b0, 1'b1, 1'b0, 1'b1);
    wake_case(14'h0002, 1'b0, 1'b0, 1'b1, 1'b1);
    wake_case(14'h0080, 1'b1, 1'b0, 1'b1, 1'b0);
    wake_case(14'h0100, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(4);
    #1 chk("reset addr", irq_addr_out, 16'hfffe);
    chk("reset lvl", 16'(irq_level_out), 16'h0003);
    cyc(1);
    rst_b_in <= 1'b1;
    t_regs();
    t_sense();
    t_ext();
    t_arb();
    final_report();
  end
  // whole run is well under a thousand cycles
  initial
  begin
    cyc(20000);
    fails++;
    final_report();
  end
endmodule
bind nested_irq_vector_ext_sense nested_irq_asserts chk_u (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .cur_prio_in(cur_prio_in), .enable_in(enable_in), .halted_in(halted_in),
  .active_halt_in(active_halt_in), .irq_valid_out(irq_valid_out), .irq_vec_out(irq_vec_out),
  .irq_addr_out(irq_addr_out), .irq_level_out(irq_level_out), .wake_out(wake_out),
  .pending_out(pending_out));
